// >>> inc/wss_cfg.svh
// Opcode encodings, register offsets, flag positions and reset values
`ifndef WSS_CFG_SVH
`define WSS_CFG_SVH
// Page prefix bytes
`define WSS_PFX_18      8'h18
`define WSS_PFX_1A      8'h1A
`define WSS_PFX_CD      8'hCD
// Store opcodes
`define WSS_OP_STS_DIR  8'h9F
`define WSS_OP_STS_EXT  8'hBF
`define WSS_OP_STS_IDX  8'hAF
`define WSS_OP_STX_DIR  8'hDF
`define WSS_OP_STX_EXT  8'hFF
`define WSS_OP_STX_IDX  8'hEF
`define WSS_OP_STY_ALT  8'hEE
// Subtract opcodes
`define WSS_OP_SUBTRACT_FROM_ACC_A_LIT 8'h80
`define WSS_OP_SUBTRACT_FROM_ACC_A_DIR 8'h90
`define WSS_OP_SUBTRACT_FROM_ACC_A_EXT 8'hB0
`define WSS_OP_SUBTRACT_FROM_ACC_A_IDX 8'hA0
`define WSS_OP_SUBB_LIT 8'hC0
`define WSS_OP_SUBB_DIR 8'hD0
`define WSS_OP_SUBB_EXT 8'hF0
`define WSS_OP_SUBB_IDX 8'hE0
`define WSS_OP_SUBTRACT_FROM_DOUBLE_LIT 8'h83
`define WSS_OP_SUBTRACT_FROM_DOUBLE_DIR 8'h93
`define WSS_OP_SUBTRACT_FROM_DOUBLE_EXT 8'hB3
`define WSS_OP_SUBTRACT_FROM_DOUBLE_IDX 8'hA3
// Bus constants
`define WSS_DUMMY_ADDR  16'hFFFF
`define WSS_PAGE0_HI    8'h00
// Condition code bit positions
`define WSS_CCR_N       3
`define WSS_CCR_Z       2
`define WSS_CCR_V       1
`define WSS_CCR_C       0
// Reset values
`define WSS_RST_PC      16'h0000
`define WSS_RST_SP      16'h0000
`define WSS_RST_CCR     8'h00
// Register byte offsets
`define WSS_REG_CTRL    8'h00
`define WSS_REG_STAT    8'h04
`define WSS_REG_PC      8'h08
`define WSS_REG_DOUBLE_ACCUMULATOR    8'h0C
`define WSS_REG_IX      8'h10
`define WSS_REG_IY      8'h14
`define WSS_REG_SP      8'h18
`define WSS_REG_CCR     8'h1C
// Response codes
`define WSS_RESP_OKAY   2'h0
`define WSS_RESP_SLVERR 2'h2
`endif

// >>> inc/wss_pkg.sv
// Types shared by the word store and subtract execution block
package wss_pkg;
  typedef enum logic [2:0] {ST_FETCH, ST_PAGE, ST_OPR1, ST_OPR2, ST_DUMMY, ST_MEM1, ST_MEM2, ST_INT} wss_state_e;
  typedef enum logic [2:0] {K_NONE, K_STS, K_STX, K_STY, K_SUBTRACT_FROM_ACC_A, K_SUBB, K_SUBTRACT_FROM_DOUBLE} wss_kind_e;
  typedef enum logic [2:0] {M_LIT, M_DIR, M_EXT, M_IDX, M_IDY} wss_mode_e;
  typedef struct packed {
    wss_kind_e kind;
    wss_mode_e mode;
  } wss_dec_s;
endpackage : wss_pkg

// >>> logic/wss_exec.sv
// Execution core for word stores and subtracts, with an AXI4-Lite register port
// How it works
// - Store X writes high byte at address, then low byte at address plus one.
// - Store Y writes high byte at address, then low byte at address plus one.
// - Word store: N from bit 15, Z if all zero, V cleared, rest kept.
// - Stack store opcodes 9F, BF, AF; prefix 18 then AF for Y offset.
// - X store opcodes DF, FF, EF; prefix CD then EF for Y offset.
// - Y store: prefix 18 with DF, FF, EF; prefix 1A with EE for X.
// - Stores fetch with reads, then two writes; direct uses 00dd, indexed adds FFFF read.
// - Stores take 4, 5, 5 cycles; each prefix adds one fetch.
// - Byte subtract puts accumulator minus operand into A or B.
// - Carry flag means borrow out of the top bit.
// - Byte subtract: N from bit 7, Z if all eight bits zero.
// - Overflow from accumulator, operand and result top bits.
// - Borrow from accumulator, operand and result top bits, no carry in.
// - Subtract A opcodes 80,90,B0,A0,18 A0; B opcodes C0,D0,F0,E0,18 E0.
// - Byte subtracts only read; 2 to 5 cycles; indexed adds FFFF read.
// - Double subtract takes high then low byte word from double accumulator.
// - Double accumulator is A high byte joined with B low byte.
// - Double subtract flags use bit 15 with the byte formulas.
// - Double subtract opcodes 83,93,B3,A3,18 A3; ends with FFFF read.
`timescale 1ns/10ps
`default_nettype none
`include "wss_cfg.svh"
module wss_exec
  import wss_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Processor memory bus
  output logic      [15:0] bus_addr,
  output logic      [7:0]  bus_wdata,
  output logic             bus_rw,
  input  wire logic [7:0]  bus_rdata,
  // AXI4-Lite write channels
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp
);

  wss_state_e  state_q, state_d;
  wss_kind_e   kind_q, kind_d;
  wss_mode_e   mode_q, mode_d;
  wss_dec_s    dec;
  logic [15:0] pc_q, pc_d, ix_q, ix_d, iy_q, iy_d, sp_q, sp_d, ea_q, ea_d, opnd_q, opnd_d;
  logic [7:0]  acc_a_q, acc_a_d, acc_b_q, acc_b_d, ccr_q, ccr_d, pfx_q, pfx_d, hi_q, hi_d;
  logic        run_q, run_d;
  logic [15:0] sv, idx_base, acc_d16, r16;
  logic [7:0]  x8, r8;
  logic        is_store, is_sub, exec8, exec16;
  // AXI state
  logic        aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        wr_go, cpu_idle;
  logic [31:0] merged;                                         // Written lanes laid over the old value

  // Opcode decode, prefix byte selects the page
  function automatic wss_dec_s decode(input logic [7:0] pfx, input logic [7:0] op);
    wss_dec_s d;
    d = '{kind: K_NONE, mode: M_LIT};
    if (pfx == 8'h00) begin
      unique case (op)
        `WSS_OP_STS_DIR:  d = '{K_STS, M_DIR};
        `WSS_OP_STS_EXT:  d = '{K_STS, M_EXT};
        `WSS_OP_STS_IDX:  d = '{K_STS, M_IDX};
        `WSS_OP_STX_DIR:  d = '{K_STX, M_DIR};
        `WSS_OP_STX_EXT:  d = '{K_STX, M_EXT};
        `WSS_OP_STX_IDX:  d = '{K_STX, M_IDX};
        `WSS_OP_SUBTRACT_FROM_ACC_A_LIT: d = '{K_SUBTRACT_FROM_ACC_A, M_LIT};
        `WSS_OP_SUBTRACT_FROM_ACC_A_DIR: d = '{K_SUBTRACT_FROM_ACC_A, M_DIR};
        `WSS_OP_SUBTRACT_FROM_ACC_A_EXT: d = '{K_SUBTRACT_FROM_ACC_A, M_EXT};
        `WSS_OP_SUBTRACT_FROM_ACC_A_IDX: d = '{K_SUBTRACT_FROM_ACC_A, M_IDX};
        `WSS_OP_SUBB_LIT: d = '{K_SUBB, M_LIT};
        `WSS_OP_SUBB_DIR: d = '{K_SUBB, M_DIR};
        `WSS_OP_SUBB_EXT: d = '{K_SUBB, M_EXT};
        `WSS_OP_SUBB_IDX: d = '{K_SUBB, M_IDX};
        `WSS_OP_SUBTRACT_FROM_DOUBLE_LIT: d = '{K_SUBTRACT_FROM_DOUBLE, M_LIT};
        `WSS_OP_SUBTRACT_FROM_DOUBLE_DIR: d = '{K_SUBTRACT_FROM_DOUBLE, M_DIR};
        `WSS_OP_SUBTRACT_FROM_DOUBLE_EXT: d = '{K_SUBTRACT_FROM_DOUBLE, M_EXT};
        `WSS_OP_SUBTRACT_FROM_DOUBLE_IDX: d = '{K_SUBTRACT_FROM_DOUBLE, M_IDX};
        default:          d = '{K_NONE, M_LIT};
      endcase
    end else if (pfx == `WSS_PFX_18) begin
      unique case (op)
        `WSS_OP_STS_IDX:  d = '{K_STS, M_IDY};
        `WSS_OP_STX_DIR:  d = '{K_STY, M_DIR};
        `WSS_OP_STX_EXT:  d = '{K_STY, M_EXT};
        `WSS_OP_STX_IDX:  d = '{K_STY, M_IDY};
        `WSS_OP_SUBTRACT_FROM_ACC_A_IDX: d = '{K_SUBTRACT_FROM_ACC_A, M_IDY};
        `WSS_OP_SUBB_IDX: d = '{K_SUBB, M_IDY};
        `WSS_OP_SUBTRACT_FROM_DOUBLE_IDX: d = '{K_SUBTRACT_FROM_DOUBLE, M_IDY};
        default:          d = '{K_NONE, M_LIT};
      endcase
    end else if (pfx == `WSS_PFX_1A && op == `WSS_OP_STY_ALT) begin
      d = '{K_STY, M_IDX};
    end else if (pfx == `WSS_PFX_CD && op == `WSS_OP_STX_IDX) begin
      d = '{K_STX, M_IDY};
    end
    return d;
  endfunction : decode

  // Overflow and borrow from the three top bits
  function automatic logic [1:0] sub_vc(input logic x, input logic m, input logic r);
    logic v, c;
    v = (x & ~m & ~r) | (~x & m & r);
    c = (~x & m) | (m & r) | (r & ~x);
    return {v, c};
  endfunction : sub_vc

  // Merge written byte lanes into an old value
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction : lanes

  // Datapath terms shared by the sequencer and its checks
  assign is_store = (kind_q == K_STS) || (kind_q == K_STX) || (kind_q == K_STY);
  assign is_sub   = (kind_q == K_SUBTRACT_FROM_ACC_A) || (kind_q == K_SUBB) || (kind_q == K_SUBTRACT_FROM_DOUBLE);
  assign sv       = (kind_q == K_STS) ? sp_q : (kind_q == K_STX) ? ix_q : iy_q;
  assign idx_base = (mode_q == M_IDY) ? iy_q : ix_q;
  assign x8       = (kind_q == K_SUBTRACT_FROM_ACC_A) ? acc_a_q : acc_b_q;
  assign r8       = x8 - bus_rdata;                            // Operand always arrives on the bus
  assign acc_d16  = {acc_a_q, acc_b_q};
  assign r16      = acc_d16 - opnd_q;
  assign cpu_idle = !run_q && (state_q == ST_FETCH);

  // Instruction sequencer, one state per bus cycle
  always_comb begin
    state_d = state_q; kind_d = kind_q; mode_d = mode_q; pc_d = pc_q; ix_d = ix_q; iy_d = iy_q;
    sp_d = sp_q; ea_d = ea_q; opnd_d = opnd_q; acc_a_d = acc_a_q; acc_b_d = acc_b_q; ccr_d = ccr_q;
    pfx_d = pfx_q; hi_d = hi_q; run_d = run_q;
    bus_addr = pc_q; bus_wdata = 8'h00; bus_rw = 1'b1;
    exec8 = 1'b0; exec16 = 1'b0;
    merged = 32'h0000_0000;
    dec = '{kind: K_NONE, mode: M_LIT};
    unique case (state_q)
      ST_FETCH: if (run_q) begin
        pc_d = pc_q + 16'h0001;
        dec  = decode(8'h00, bus_rdata);
        if (bus_rdata == `WSS_PFX_18 || bus_rdata == `WSS_PFX_1A || bus_rdata == `WSS_PFX_CD) begin
          pfx_d = bus_rdata; state_d = ST_PAGE;     // Prefix costs one fetch
        end else if (dec.kind != K_NONE) begin
          kind_d = dec.kind; mode_d = dec.mode; state_d = ST_OPR1;
        end                                         // Other opcodes pass as one-byte no-ops
      end
      ST_PAGE: begin
        pc_d = pc_q + 16'h0001;
        dec  = decode(pfx_q, bus_rdata);
        kind_d = dec.kind; mode_d = dec.mode;
        state_d = (dec.kind == K_NONE) ? ST_FETCH : ST_OPR1;
      end
      ST_OPR1: begin
        pc_d = pc_q + 16'h0001;
        hi_d = bus_rdata;
        unique case (mode_q)
          M_LIT: if (kind_q == K_SUBTRACT_FROM_DOUBLE) state_d = ST_OPR2;
                 else begin exec8 = 1'b1; state_d = ST_FETCH; end
          M_DIR: begin ea_d = {`WSS_PAGE0_HI, bus_rdata}; state_d = ST_MEM1; end
          M_EXT: state_d = ST_OPR2;
          M_IDX, M_IDY: begin
            ea_d = idx_base + {8'h00, bus_rdata};   // Wraps at 64K
            state_d = ST_DUMMY;
          end
        endcase
      end
      ST_OPR2: begin
        pc_d = pc_q + 16'h0001;
        if (mode_q == M_LIT) begin opnd_d = {hi_q, bus_rdata}; state_d = ST_INT; end
        else begin ea_d = {hi_q, bus_rdata}; state_d = ST_MEM1; end
      end
      ST_DUMMY: begin
        bus_addr = `WSS_DUMMY_ADDR;                 // Indexed idle read
        state_d  = ST_MEM1;
      end
      ST_MEM1: begin
        bus_addr = ea_q;
        if (is_store) begin
          bus_rw = 1'b0; bus_wdata = sv[15:8]; state_d = ST_MEM2;
        end else if (kind_q == K_SUBTRACT_FROM_DOUBLE) begin
          opnd_d[15:8] = bus_rdata; state_d = ST_MEM2;
        end else begin
          exec8 = 1'b1; state_d = ST_FETCH;
        end
      end
      ST_MEM2: begin
        bus_addr = ea_q + 16'h0001;
        if (is_store) begin
          bus_rw = 1'b0; bus_wdata = sv[7:0]; state_d = ST_FETCH;
          ccr_d[`WSS_CCR_N] = sv[15];
          ccr_d[`WSS_CCR_Z] = (sv == 16'h0000);
          ccr_d[`WSS_CCR_V] = 1'b0;
        end else begin
          opnd_d[7:0] = bus_rdata; state_d = ST_INT;
        end
      end
      ST_INT: begin
        bus_addr = `WSS_DUMMY_ADDR;
        exec16   = 1'b1;
        state_d  = ST_FETCH;
      end
    endcase
    // Byte subtract result and flags
    if (exec8) begin
      if (kind_q == K_SUBTRACT_FROM_ACC_A) acc_a_d = r8; else acc_b_d = r8;
      ccr_d[`WSS_CCR_N] = r8[7];
      ccr_d[`WSS_CCR_Z] = (r8 == 8'h00);
      {ccr_d[`WSS_CCR_V], ccr_d[`WSS_CCR_C]} = sub_vc(x8[7], bus_rdata[7], r8[7]);
    end
    // Double subtract result and flags
    if (exec16) begin
      {acc_a_d, acc_b_d} = r16;
      ccr_d[`WSS_CCR_N] = r16[15];
      ccr_d[`WSS_CCR_Z] = (r16 == 16'h0000);
      {ccr_d[`WSS_CCR_V], ccr_d[`WSS_CCR_C]} = sub_vc(acc_d16[15], opnd_q[15], r16[15]);
    end
    // Register loads only while halted, so they never race an instruction; the run bit is taken at any time
    if (wr_go && awaddr_q == `WSS_REG_CTRL && wstrb_q[0]) run_d = wdata_q[0];
    if (wr_go && cpu_idle) begin
      unique case (awaddr_q)
        `WSS_REG_PC: begin
          merged = lanes({16'h0, pc_q}, wdata_q, wstrb_q);
          pc_d   = merged[15:0];
        end
        `WSS_REG_DOUBLE_ACCUMULATOR: begin
          merged             = lanes({16'h0, acc_d16}, wdata_q, wstrb_q);
          {acc_a_d, acc_b_d} = merged[15:0];
        end
        `WSS_REG_IX: begin
          merged = lanes({16'h0, ix_q}, wdata_q, wstrb_q);
          ix_d   = merged[15:0];
        end
        `WSS_REG_IY: begin
          merged = lanes({16'h0, iy_q}, wdata_q, wstrb_q);
          iy_d   = merged[15:0];
        end
        `WSS_REG_SP: begin
          merged = lanes({16'h0, sp_q}, wdata_q, wstrb_q);
          sp_d   = merged[15:0];
        end
        `WSS_REG_CCR: begin
          merged = lanes({24'h0, ccr_q}, wdata_q, wstrb_q);
          ccr_d  = merged[7:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_FETCH; kind_q <= K_NONE; mode_q <= M_LIT; pc_q <= `WSS_RST_PC;
      ix_q <= 16'h0000; iy_q <= 16'h0000; sp_q <= `WSS_RST_SP; ea_q <= 16'h0000; opnd_q <= 16'h0000;
      acc_a_q <= 8'h00; acc_b_q <= 8'h00; ccr_q <= `WSS_RST_CCR; pfx_q <= 8'h00; hi_q <= 8'h00;
      run_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d; kind_q <= kind_d; mode_q <= mode_d; pc_q <= pc_d;
      ix_q <= ix_d; iy_q <= iy_d; sp_q <= sp_d; ea_q <= ea_d; opnd_q <= opnd_d;
      acc_a_q <= acc_a_d; acc_b_q <= acc_b_d; ccr_q <= ccr_d; pfx_q <= pfx_d; hi_q <= hi_d;
      run_q <= run_d;
    end
  end

  // AXI4-Lite slave: address and data latched separately, in any order
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go         = aw_q && w_q && !bvalid_q;

  always_comb begin
    aw_d = aw_q; w_d = w_q; bvalid_d = bvalid_q; rvalid_d = rvalid_q;
    awaddr_d = awaddr_q; wdata_d = wdata_q; wstrb_d = wstrb_q;
    bresp_d = bresp_q; rdata_d = rdata_q; rresp_d = rresp_q;
    if (s_axi_awvalid && !aw_q) begin aw_d = 1'b1; awaddr_d = s_axi_awaddr; end
    if (s_axi_wvalid && !w_q) begin w_d = 1'b1; wdata_d = s_axi_wdata; wstrb_d = s_axi_wstrb; end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (wr_go) begin
      aw_d = 1'b0; w_d = 1'b0; bvalid_d = 1'b1;
      bresp_d = (awaddr_q[7:5] == 3'h0 && awaddr_q[1:0] == 2'h0 && awaddr_q != `WSS_REG_STAT)
                ? `WSS_RESP_OKAY : `WSS_RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1; rresp_d = `WSS_RESP_OKAY;
      unique case (s_axi_araddr)
        `WSS_REG_CTRL: rdata_d = {31'h0, run_q};
        `WSS_REG_STAT: rdata_d = {24'h0, kind_q, state_q, 1'b0, (state_q != ST_FETCH)};
        `WSS_REG_PC:   rdata_d = {16'h0, pc_q};
        `WSS_REG_DOUBLE_ACCUMULATOR: rdata_d = {16'h0, acc_d16};
        `WSS_REG_IX:   rdata_d = {16'h0, ix_q};
        `WSS_REG_IY:   rdata_d = {16'h0, iy_q};
        `WSS_REG_SP:   rdata_d = {16'h0, sp_q};
        `WSS_REG_CCR:  rdata_d = {24'h0, ccr_q};
        default: begin rdata_d = 32'h0; rresp_d = `WSS_RESP_SLVERR; end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; bvalid_q <= 1'b0; rvalid_q <= 1'b0; awaddr_q <= 8'h00;
      wdata_q <= 32'h0; wstrb_q <= 4'h0; bresp_q <= 2'h0; rdata_q <= 32'h0; rresp_q <= 2'h0;
    end else if (ce) begin
      aw_q <= aw_d; w_q <= w_d; bvalid_q <= bvalid_d; rvalid_q <= rvalid_d; awaddr_q <= awaddr_d;
      wdata_q <= wdata_d; wstrb_q <= wstrb_d; bresp_q <= bresp_d; rdata_q <= rdata_d; rresp_q <= rresp_d;
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_hi_write;
    ce && state_q == ST_MEM1 && is_store;
  endsequence
  sequence s_lo_write;
    state_q == ST_MEM2 && !bus_rw;
  endsequence
  store_hi_byte_a: assert property (state_q == ST_MEM1 && is_store |-> !bus_rw && bus_wdata == sv[15:8])
    else $error("high byte not written first");
  store_pair_a: assert property (s_hi_write |=> s_lo_write ##0 bus_addr == $past(bus_addr) + 16'h0001)
    else $error("low byte not written at next address");
  store_flags_a: assert property (ce && state_q == ST_MEM2 && is_store |=> ccr_q[3] == $past(sv[15])
    && ccr_q[2] == ($past(sv) == 16'h0000) && !ccr_q[1] && ccr_q[0] == $past(ccr_q[0]))
    else $error("store flags wrong");
  sub_reads_a: assert property (is_sub && state_q != ST_FETCH |-> bus_rw)
    else $error("subtract drove a write");
  idx_offset_a: assert property (ce && state_q == ST_OPR1 && (mode_q == M_IDX || mode_q == M_IDY)
    |=> state_q == ST_DUMMY && bus_addr == 16'hFFFF && ea_q == $past(idx_base) + {8'h00, $past(bus_rdata)})
    else $error("indexed address wrong");
  subtract_from_double_tail_a: assert property (ce && state_q == ST_MEM2 && kind_q == K_SUBTRACT_FROM_DOUBLE |=> state_q == ST_INT
    && bus_addr == 16'hFFFF && bus_rw)
    else $error("double subtract missing idle read");
  sub8_borrow_a: assert property (ce && exec8 |=> ccr_q[0] == ($past(x8) < $past(bus_rdata))
    && ccr_q[3] == $past(r8[7]) && ccr_q[2] == ($past(r8) == 8'h00))
    else $error("byte subtract flags wrong");
  subtract_from_double_result_a: assert property (ce && exec16 |=> {acc_a_q, acc_b_q} == $past(acc_d16) - $past(opnd_q)
    && ccr_q[0] == ($past(acc_d16) < $past(opnd_q)))
    else $error("double subtract result wrong");
endmodule : wss_exec
`default_nettype wire

// >>> dv/wss_mem.sv
// Behavioural byte memory standing on the far side of the processor bus
`timescale 1ns/10ps
`default_nettype none
module wss_mem (
  // Clock and enable
  input  wire logic        aclk,
  input  wire logic        ce,
  // Processor bus
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_rw,
  output logic      [7:0]  bus_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  // Unused space reads as a byte the core treats as a no-op
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    last_q = 8'h00;
  end
  // Reads answer in the same cycle; on write cycles the line flips so stale data is never trusted
  assign bus_rdata = bus_rw ? mem[bus_addr] : ~last_q;
  // Writes land at the edge that closes the cycle
  always @(posedge aclk) begin
    if (ce) begin
      if (!bus_rw) mem[bus_addr] <= bus_wdata;
      last_q <= bus_rdata;
    end
  end
endmodule : wss_mem
`default_nettype wire

// >>> dv/word_store_and_subtract_exec_tb.sv
// Self-checking bench for the word store and subtract execution block
`timescale 1ns/10ps
`default_nettype none
`include "wss_cfg.svh"
module word_store_and_subtract_exec_tb;
  localparam int          LIMIT = 20000;
  localparam logic [15:0] BASE  = 16'h8000;
  // Prefix and opcode per kind and mode; prefix zero when absent
  localparam logic [15:0] OPT [6][5] = '{
    '{16'h0000, 16'h009F, 16'h00BF, 16'h00AF, 16'h18AF},
    '{16'h0000, 16'h00DF, 16'h00FF, 16'h00EF, 16'hCDEF},
    '{16'h0000, 16'h18DF, 16'h18FF, 16'h1AEE, 16'h18EF},
    '{16'h0080, 16'h0090, 16'h00B0, 16'h00A0, 16'h18A0},
    '{16'h00C0, 16'h00D0, 16'h00F0, 16'h00E0, 16'h18E0},
    '{16'h0083, 16'h0093, 16'h00B3, 16'h00A3, 16'h18A3}};
  logic        aclk, aresetn, ce, bus_rw, cap_q;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [24:0] got[$], exp_q[$];
  int          fails, total_checks, seed, cyc;
  wss_exec u_wss_exec (.aclk(aclk), .aresetn(aresetn), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rw(bus_rw), .bus_rdata(bus_rdata), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  wss_mem u_wss_mem (.aclk(aclk), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rw(bus_rw),
    .bus_rdata(bus_rdata));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Bus trace; the idle fetch address repeats while halted, so only one copy is kept
  always @(posedge aclk) begin
    cyc++;
    if (cap_q && ce && !(got.size() == 1 && {bus_addr, bus_rw, bus_wdata} === got[0]))
      got.push_back({bus_addr, bus_rw, bus_wdata});
    if (cyc > LIMIT) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] want);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, want);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  // Subtract flags from the top bits of minuend, operand and result; upper bits kept
  function automatic logic [7:0] fl(logic [7:0] c, logic x, logic m, logic r, logic z);
    return {c[7:4], r, z, (x & ~m & ~r) | (~x & m & r), (~x & m) | (m & r) | (r & ~x)};
  endfunction : fl
  // One instruction from a halted core: load, run, halt, compare trace and registers
  task automatic run_one(input int k, input int m, input int rep);
    logic [31:0] v;
    logic [15:0] ix, iy, sp, d, m16, ea, wv, oc, nd, r16;
    logic [7:0]  c, ofs, cx, r8;
    logic [1:0]  rs;
    logic [7:0]  prog[$];
    ix = 16'($random(seed)) & 16'h3FFF;
    iy = 16'($random(seed)) & 16'h3FFF;
    sp = 16'($random(seed));
    d = 16'($random(seed));
    m16 = 16'($random(seed));
    c = 8'($random(seed));
    ofs = 8'($random(seed));
    ea = 16'($random(seed)) & 16'h3FFF;
    // Corner: offset sums wrap, and a word straddles the top of memory
    if (rep == 0) begin
      ix = 16'hFFC0;
      iy = 16'hFFC0;
      ofs = 8'hF0;
      ea = 16'hFFFF;
    end
    // Corner: zero stored word, zero difference
    if (rep == 2) begin
      ix = 16'h0000;
      iy = 16'h0000;
      sp = 16'h0000;
      m16 = (k == 4) ? {d[7:0], 8'h00} : d;
    end
    ea = (m == 1) ? {8'h00, ofs} : (m == 3) ? ix + {8'h00, ofs} : (m == 4) ? iy + {8'h00, ofs} : ea;
    oc = OPT[k][m];
    if (oc[15:8] != 8'h00) prog.push_back(oc[15:8]);
    prog.push_back(oc[7:0]);
    if (m == 2 || (m == 0 && k == 5)) prog.push_back(m == 2 ? ea[15:8] : m16[15:8]);
    prog.push_back(m == 2 ? ea[7:0] : m == 0 ? (k == 5 ? m16[7:0] : m16[15:8]) : ofs);
    for (int i = 0; i < 8; i++) u_wss_mem.mem[BASE + 16'(i)] = 8'h00;
    foreach (prog[i]) u_wss_mem.mem[BASE + 16'(i)] = prog[i];
    u_wss_mem.mem[ea] = m16[15:8];
    u_wss_mem.mem[ea + 16'h0001] = m16[7:0];
    exp_q.delete();
    foreach (prog[i]) exp_q.push_back({BASE + 16'(i), 1'b1, 8'h00});
    if (m >= 3) exp_q.push_back({16'hFFFF, 1'b1, 8'h00});
    wv = (k == 0) ? sp : (k == 1) ? ix : iy;
    if (k < 3) exp_q.push_back({ea, 1'b0, wv[15:8]});
    if (k < 3) exp_q.push_back({ea + 16'h0001, 1'b0, wv[7:0]});
    if (k > 2 && m > 0) exp_q.push_back({ea, 1'b1, 8'h00});
    if (k == 5 && m > 0) exp_q.push_back({ea + 16'h0001, 1'b1, 8'h00});
    if (k == 5) exp_q.push_back({16'hFFFF, 1'b1, 8'h00});
    r8 = ((k == 3) ? d[15:8] : d[7:0]) - m16[15:8];
    r16 = d - m16;
    nd = (k == 3) ? {r8, d[7:0]} : (k == 4) ? {d[15:8], r8} : (k == 5) ? r16 : d;
    cx = (k < 3) ? {c[7:4], wv[15], wv == 16'h0000, 1'b0, c[0]} : (k == 5) ?
      fl(c, d[15], m16[15], r16[15], r16 == 16'h0000) : fl(c, r8[7] ^ m16[15] ^ 1'b0 ? 1'b0 : 1'b0, 1'b0, 1'b0, 1'b0);
    if (k == 3 || k == 4) cx = fl(c, (k == 3) ? d[15] : d[7], m16[15], r8[7], r8 == 8'h00);
    wr(`WSS_REG_PC, {16'h0000, BASE}, `WSS_RESP_OKAY);
    wr(`WSS_REG_DOUBLE_ACCUMULATOR, {16'h0000, d}, `WSS_RESP_OKAY);
    wr(`WSS_REG_IX, {16'h0000, ix}, `WSS_RESP_OKAY);
    wr(`WSS_REG_IY, {16'h0000, iy}, `WSS_RESP_OKAY);
    wr(`WSS_REG_SP, {16'h0000, sp}, `WSS_RESP_OKAY);
    wr(`WSS_REG_CCR, {24'h000000, c}, `WSS_RESP_OKAY);
    got.delete();
    cap_q <= 1'b1;
    wr(`WSS_REG_CTRL, 32'h00000001, `WSS_RESP_OKAY);
    // Random enable gaps only stretch the trace, never change it
    for (int i = 0; i < 60 && got.size() <= exp_q.size(); i++) begin
      ce <= (($random(seed) & 3) != 0);
      @(posedge aclk);
    end
    ce <= 1'b1;
    cap_q <= 1'b0;
    wr(`WSS_REG_CTRL, 32'h00000000, `WSS_RESP_OKAY);
    do rd(`WSS_REG_STAT, v, rs); while (v[0] !== 1'b0);
    chk(32'(got.size() > exp_q.size()), 32'h1);
    foreach (exp_q[i]) chk(got[i], exp_q[i]);
    chk(got[exp_q.size()][24:9], BASE + 16'(prog.size()));
    rd(`WSS_REG_DOUBLE_ACCUMULATOR, v, rs);
    chk(v, {16'h0000, nd});
    rd(`WSS_REG_CCR, v, rs);
    chk(v, {24'h000000, cx});
  endtask : run_one
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [1:0]  rs;
    seed = 15324;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    cap_q = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, an unmapped read and a write to the read-only status word
    rd(`WSS_REG_CTRL, v, rs);
    chk(v, 32'h00000000);
    rd(`WSS_REG_CCR, v, rs);
    chk(v, 32'h00000000);
    rd(8'h40, v, rs);
    chk({v[29:0], rs}, {30'h0, `WSS_RESP_SLVERR});
    wr(`WSS_REG_STAT, 32'h00000001, `WSS_RESP_SLVERR);
    for (int rep = 0; rep < 3; rep++)
      for (int k = 0; k < 6; k++)
        for (int m = 0; m < 5; m++)
          if (k > 2 || m > 0) run_one(k, m, rep);
    summarize();
  end
endmodule : word_store_and_subtract_exec_tb
`default_nettype wire
